// ===== src/iscp_consts.vh
// constants shared by the image sensor control port design
`ifndef ISCP_CONSTS_VH
`define ISCP_CONSTS_VH

// ----------------------------------------------------------------
// register addresses (7-bit serial address space)
// ----------------------------------------------------------------
`define ISCP_ADDR_EXPOSURE_SELECT 7'h46
`define ISCP_ADDR_EXPOSURE_TIME_LO 7'h47
`define ISCP_ADDR_EXPOSURE_TIME_HI 7'h48
`define ISCP_ADDR_FRAME_COUNT 7'h50
`define ISCP_ADDR_PIXEL_RESOLUTION 7'h76
`define ISCP_REG_COUNT 128

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define ISCP_EXT_MODE_BIT 0
`define ISCP_FRAME_COUNT_RST 16'h0001
`define ISCP_REG_RST 16'h0000

// ----------------------------------------------------------------
// serial word layout
// ----------------------------------------------------------------
`define ISCP_CTRL_INDEX 5'h00
`define ISCP_ADDR_LSB_INDEX 5'h07
`define ISCP_LAST_INDEX 5'h17

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ISCP_CLK_MHZ 20
`define ISCP_MAX_RATE_MBPS 600
`define ISCP_FOT_CYCLES 16
`define ISCP_READOUT_CYCLES 64

// ----------------------------------------------------------------
// exposure sequencer states
// ----------------------------------------------------------------
`define ISCP_ST_IDLE 2'h0
`define ISCP_ST_INTEGRATION_PHASE 2'h1
`define ISCP_ST_WAIT 2'h2
`define ISCP_ST_FOT 2'h3

`endif

// ===== src/iscp_serial.v
// serial register interface slave, sampled on the system clock
`timescale 1ns/1ns
`include "iscp_consts.vh"

module iscp_serial (
  input wire clk,
  input wire rstn,
  input wire spi_clk,
  input wire spi_en,
  input wire spi_in,
  input wire [15:0] rd_data,
  output reg spi_out,
  output reg wr_pulse,
  output reg [6:0] reg_addr,
  output reg [15:0] wr_data
);

  // ----------------------------------------------------------------
  // synchronisers: clock, enable and data share the same delay
  // ----------------------------------------------------------------
  reg [2:0] meta_reg;
  reg [2:0] sync_reg;
  reg sclk_prev_reg;
  wire sclk_rise;
  wire sclk_fall;
  wire en_s;
  wire din_s;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      sclk_prev_reg <= 1'b0;
    end else begin
      meta_reg <= {spi_in, spi_en, spi_clk};
      sync_reg <= meta_reg;
      sclk_prev_reg <= sync_reg[0];
    end
  end

  assign sclk_rise = sync_reg[0] & ~sclk_prev_reg;
  assign sclk_fall = ~sync_reg[0] & sclk_prev_reg;
  assign en_s = sync_reg[1];
  assign din_s = sync_reg[2];

  // ----------------------------------------------------------------
  // word assembly
  // ----------------------------------------------------------------
  reg [4:0] bit_cnt_reg;
  reg [14:0] shift_reg;
  reg write_reg;
  reg commit_reg;
  reg load_reg;
  reg reading_reg;
  reg [15:0] out_shift_reg;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_reg <= 5'h00;
      shift_reg <= 15'h0000;
      write_reg <= 1'b0;
      commit_reg <= 1'b0;
      load_reg <= 1'b0;
      reading_reg <= 1'b0;
      out_shift_reg <= 16'h0000;
      spi_out <= 1'b0;
      wr_pulse <= 1'b0;
      reg_addr <= 7'h00;
      wr_data <= 16'h0000;
    end else begin
      wr_pulse <= 1'b0;
      if (!en_s) begin
        // idle interface: counters cleared, output held low
        bit_cnt_reg <= 5'h00;
        load_reg <= 1'b0;
        reading_reg <= 1'b0;
        spi_out <= 1'b0;
      end else if (sclk_rise) begin
        shift_reg <= {shift_reg[13:0], din_s};
        if (bit_cnt_reg == `ISCP_CTRL_INDEX) begin
          write_reg <= din_s;
        end
        if (bit_cnt_reg == `ISCP_ADDR_LSB_INDEX) begin
          reg_addr <= {shift_reg[5:0], din_s};
          load_reg <= ~write_reg;
        end
        if (bit_cnt_reg == `ISCP_LAST_INDEX) begin
          // read words drop their trailing bits here
          commit_reg <= write_reg;
          wr_data <= {shift_reg, din_s};
          reading_reg <= 1'b0;
          bit_cnt_reg <= 5'h00;
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      end
      if (sclk_fall) begin
        if (commit_reg) begin
          // commit on the falling edge after the last bit
          wr_pulse <= 1'b1;
          commit_reg <= 1'b0;
        end
        if (en_s && load_reg) begin
          // no sub-cycle delay possible: launch lands on the edge
          spi_out <= rd_data[15];
          out_shift_reg <= {rd_data[14:0], 1'b0};
          load_reg <= 1'b0;
          reading_reg <= 1'b1;
        end else if (en_s && reading_reg) begin
          spi_out <= out_shift_reg[15];
          out_shift_reg <= {out_shift_reg[14:0], 1'b0};
        end else begin
          spi_out <= 1'b0;
        end
      end
    end
  end

endmodule // iscp_serial

// ===== src/iscp_top.v
// image sensor control port: registers, reset and frame sequencer
// How it works
// - output bit rate equals input clock rate
// - reset falling edge clears sequencer, registers
// - every written register reads back serially
// - serial lines held low when idle
// - sample rising edges, commit last falling
// - 24 bits: control, 7 address, 16 data
// - back-to-back words under one enable
// - request captures programmed frame count frames
// - internal exposure, overhead, then automatic readout
// - next exposure overlaps previous readout
// - short exposure waits for readout end
// - early requests delayed, at most two remembered
// - continuous request gives back-to-back frames
// - external mode: pin starts, request ends
// - early external end extends exposure
`timescale 1ns/1ns
`include "iscp_consts.vh"

module iscp_top #(
  parameter FOT_CYCLES = `ISCP_FOT_CYCLES,
  parameter READOUT_CYCLES = `ISCP_READOUT_CYCLES
) (
  input wire clk,
  input wire rstn,
  input wire system_reset_low,
  input wire frame_req,
  input wire exposure_pin_one,
  input wire spi_clk,
  input wire spi_en,
  input wire spi_in,
  output wire spi_out,
  output reg integration_phase,
  output reg frame_overhead_time,
  output reg readout_active,
  output reg data_out,
  output reg frame_done
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [15:0] iscp_default;
    input [6:0] addr;
    begin
      if (addr == `ISCP_ADDR_FRAME_COUNT) begin
        iscp_default = `ISCP_FRAME_COUNT_RST;
      end else begin
        iscp_default = `ISCP_REG_RST;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [2:0] meta_reg;
  reg [2:0] sync_reg;
  reg [2:0] prev_reg;
  wire seq_clear;
  wire req_level;
  wire exp_rise;
  wire req_rise;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // reset pin idles high, request pins idle low: no false edge
      meta_reg <= 3'h1;
      sync_reg <= 3'h1;
      prev_reg <= 3'h1;
    end else begin
      meta_reg <= {exposure_pin_one, frame_req, system_reset_low};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // a falling edge starts the clear, a held low keeps it
  assign seq_clear = ~sync_reg[0];
  assign req_level = sync_reg[1];
  assign req_rise = sync_reg[1] & ~prev_reg[1];
  assign exp_rise = sync_reg[2] & ~prev_reg[2];

  // ----------------------------------------------------------------
  // programming registers
  // ----------------------------------------------------------------
  reg [15:0] regs_reg [0:`ISCP_REG_COUNT-1];
  wire wr_pulse;
  wire [6:0] reg_addr;
  wire [15:0] wr_data;
  wire [15:0] rd_data;
  integer i;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (i = 0; i < `ISCP_REG_COUNT; i = i + 1) begin
        regs_reg[i] <= iscp_default(i[6:0]);
      end
    end else if (seq_clear) begin
      for (i = 0; i < `ISCP_REG_COUNT; i = i + 1) begin
        regs_reg[i] <= iscp_default(i[6:0]);
      end
    end else if (wr_pulse) begin
      regs_reg[reg_addr] <= wr_data;
    end
  end

  assign rd_data = regs_reg[reg_addr];

  iscp_serial u_serial (
    .clk(clk),
    .rstn(rstn),
    .spi_clk(spi_clk),
    .spi_en(spi_en),
    .spi_in(spi_in),
    .rd_data(rd_data),
    .spi_out(spi_out),
    .wr_pulse(wr_pulse),
    .reg_addr(reg_addr),
    .wr_data(wr_data)
  );

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  wire ext_mode;
  wire [31:0] exp_time;
  wire [15:0] frames_eff;

  assign ext_mode =
    regs_reg[`ISCP_ADDR_EXPOSURE_SELECT][`ISCP_EXT_MODE_BIT];
  assign exp_time = {regs_reg[`ISCP_ADDR_EXPOSURE_TIME_HI],
                     regs_reg[`ISCP_ADDR_EXPOSURE_TIME_LO]};
  // a zero count would hang a request, so it acts as one
  assign frames_eff = (regs_reg[`ISCP_ADDR_FRAME_COUNT] == 16'h0000) ?
    16'h0001 : regs_reg[`ISCP_ADDR_FRAME_COUNT];

  // ----------------------------------------------------------------
  // request bookkeeping
  // ----------------------------------------------------------------
  reg [1:0] exp_state_reg;
  reg [31:0] exp_cnt_reg;
  reg [31:0] ro_cnt_reg;
  reg [15:0] frames_left_reg;
  reg [1:0] pending_reg;
  reg armed_reg;
  wire ro_busy;
  wire seq_idle;
  wire req_new;
  wire pend_inc;
  wire pend_dec;
  wire start_int;
  wire end_exp;

  assign ro_busy = (ro_cnt_reg != 32'h0);
  assign seq_idle = (exp_state_reg == `ISCP_ST_IDLE) &&
                    (frames_left_reg == 16'h0000) &&
                    (pending_reg == 2'h0);
  // a level still high after a sequence re-arms at once
  assign req_new = ~ext_mode & req_level & ~armed_reg;
  // any request while work is queued waits; only two are kept
  assign pend_inc = req_new && !seq_idle &&
                    (pending_reg != 2'h2);
  assign pend_dec = (exp_state_reg == `ISCP_ST_IDLE) &&
                    (frames_left_reg == 16'h0000) &&
                    (pending_reg != 2'h0);
  assign start_int = ~ext_mode &&
                     (exp_state_reg == `ISCP_ST_IDLE) &&
                     (frames_left_reg != 16'h0000);
  assign end_exp = ext_mode ? req_rise :
                   (exp_cnt_reg <= 32'h1);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frames_left_reg <= 16'h0000;
      pending_reg <= 2'h0;
      armed_reg <= 1'b0;
    end else if (seq_clear) begin
      frames_left_reg <= 16'h0000;
      pending_reg <= 2'h0;
      armed_reg <= 1'b0;
    end else begin
      if (!req_level || (seq_idle && !req_new)) begin
        armed_reg <= 1'b0;
      end else if (req_new) begin
        armed_reg <= 1'b1;
      end
      if (start_int) begin
        frames_left_reg <= frames_left_reg - 16'h0001;
      end else if (frames_left_reg == 16'h0000) begin
        if (pend_dec || (req_new && seq_idle)) begin
          frames_left_reg <= frames_eff;
        end
      end
      if (pend_inc && !pend_dec) begin
        pending_reg <= pending_reg + 2'h1;
      end else if (pend_dec && !pend_inc) begin
        pending_reg <= pending_reg - 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // exposure sequencer
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      exp_state_reg <= `ISCP_ST_IDLE;
      exp_cnt_reg <= 32'h0;
    end else if (seq_clear) begin
      exp_state_reg <= `ISCP_ST_IDLE;
      exp_cnt_reg <= 32'h0;
    end else begin
      case (exp_state_reg)
        `ISCP_ST_IDLE: begin
          if (start_int) begin
            exp_state_reg <= `ISCP_ST_INTEGRATION_PHASE;
            exp_cnt_reg <= exp_time;
          end else if (ext_mode && exp_rise) begin
            exp_state_reg <= `ISCP_ST_INTEGRATION_PHASE;
            exp_cnt_reg <= 32'h0;
          end
        end
        `ISCP_ST_INTEGRATION_PHASE: begin
          if (end_exp) begin
            // a busy readout delays the overhead phase
            if (ro_busy) begin
              exp_state_reg <= `ISCP_ST_WAIT;
            end else begin
              exp_state_reg <= `ISCP_ST_FOT;
              exp_cnt_reg <= FOT_CYCLES;
            end
          end else if (!ext_mode) begin
            exp_cnt_reg <= exp_cnt_reg - 32'h1;
          end
        end
        `ISCP_ST_WAIT: begin
          if (!ro_busy) begin
            exp_state_reg <= `ISCP_ST_FOT;
            exp_cnt_reg <= FOT_CYCLES;
          end
        end
        `ISCP_ST_FOT: begin
          if (exp_cnt_reg <= 32'h1) begin
            exp_state_reg <= `ISCP_ST_IDLE;
            exp_cnt_reg <= 32'h0;
          end else begin
            exp_cnt_reg <= exp_cnt_reg - 32'h1;
          end
        end
        default: begin
          exp_state_reg <= `ISCP_ST_IDLE;
          exp_cnt_reg <= 32'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // readout engine
  // ----------------------------------------------------------------
  wire fot_last;

  assign fot_last = (exp_state_reg == `ISCP_ST_FOT) &&
                    (exp_cnt_reg <= 32'h1);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ro_cnt_reg <= 32'h0;
    end else if (seq_clear) begin
      ro_cnt_reg <= 32'h0;
    end else if (fot_last) begin
      ro_cnt_reg <= READOUT_CYCLES;
    end else if (ro_busy) begin
      ro_cnt_reg <= ro_cnt_reg - 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      integration_phase <= 1'b0;
      frame_overhead_time <= 1'b0;
      readout_active <= 1'b0;
      data_out <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      integration_phase <= (exp_state_reg == `ISCP_ST_INTEGRATION_PHASE) ||
                           (exp_state_reg == `ISCP_ST_WAIT);
      frame_overhead_time <= (exp_state_reg == `ISCP_ST_FOT);
      readout_active <= ro_busy;
      // one bit per clock: line rate tracks the input clock
      data_out <= ro_busy & (ro_cnt_reg[0] ^ ro_cnt_reg[3]);
      frame_done <= (ro_cnt_reg == 32'h1) && !seq_clear;
    end
  end

endmodule // iscp_top

// ===== verification/iscp_top_asserts.sv
// assertion checker for the image sensor control port outputs
`timescale 1ns/1ns
module iscp_top_asserts #(
  parameter FOT_CYCLES = 16,
  parameter READOUT_CYCLES = 64
) (
  input logic clk,
  input logic rstn,
  input logic system_reset_low,
  input logic frame_req,
  input logic exposure_pin_one,
  input logic spi_clk,
  input logic spi_en,
  input logic spi_in,
  input logic spi_out,
  input logic integration_phase,
  input logic frame_overhead_time,
  input logic readout_active,
  input logic data_out,
  input logic frame_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----
  // phase length counters, too long for a repetition
  // ----
  logic [15:0] fot_cnt;
  logic [15:0] ro_cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fot_cnt <= 16'h0000;
      ro_cnt <= 16'h0000;
    end else begin
      fot_cnt <= frame_overhead_time ? fot_cnt + 16'h0001 : 16'h0000;
      ro_cnt <= readout_active ? ro_cnt + 16'h0001 : 16'h0000;
    end
  end
  sequence s_ro_follows;
    ##[0:1] readout_active;
  endsequence
  sequence s_done_pulse;
    readout_active ##1 (!frame_done && !readout_active);
  endsequence
  // ----
  // assertions
  // ----
  a_spi_idle_low: assert property (!spi_en [*6] |-> !spi_out)
    else $error("serial output high while enable low");
  a_fot_length: assert property ($fell(frame_overhead_time) |->
    fot_cnt == FOT_CYCLES) else $error("overhead length wrong");
  a_readout_length: assert property ($fell(readout_active) |->
    ro_cnt == READOUT_CYCLES) else $error("readout length wrong");
  a_fot_to_readout: assert property ($fell(frame_overhead_time) |->
    s_ro_follows) else $error("readout did not follow overhead");
  // done stands in the last readout cycle, so look one back
  a_done_after_ro: assert property ($fell(readout_active) |->
    $past(frame_done)) else $error("no done pulse after readout");
  a_done_single: assert property (frame_done |-> s_done_pulse)
    else $error("done pulse too long");
  a_data_in_readout: assert property (data_out |->
    readout_active) else $error("line data outside readout");
  a_fot_no_overlap: assert property (frame_overhead_time |->
    !readout_active) else $error("overhead during readout");
  a_integration_phase_before_fot: assert property ($rose(frame_overhead_time) |->
    $past(integration_phase)) else $error("overhead without exposure");
  a_reset_idle: assert property (!system_reset_low [*6] |->
    !(integration_phase || frame_overhead_time || readout_active))
    else $error("sequencer busy under reset pin");
endmodule // iscp_top_asserts

bind iscp_top iscp_top_asserts #(.FOT_CYCLES(FOT_CYCLES),
  .READOUT_CYCLES(READOUT_CYCLES)) u_chk (.*);

// ===== verification/iscp_host.sv
// host model driving the serial register pins
`timescale 1ns/1ns
module iscp_host (
  input logic clk,
  input logic spi_out,
  output logic spi_clk,
  output logic spi_en,
  output logic spi_in
);
  initial begin
    spi_clk = 1'b0;
    spi_en = 1'b0;
    spi_in = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ----
  // one word, 400 ns period; clock stands still between words
  // ----
  task automatic xfer(input logic [23:0] w, input bit keep,
      output logic [15:0] r);
    r = 16'h0000;
    spi_en <= 1'b1;
    for (int i = 23; i >= 0; i--) begin
      spi_in <= w[i];
      wt(4);
      spi_clk <= 1'b1;
      wt(4);
      if (i < 16) r = {r[14:0], spi_out};
      spi_clk <= 1'b0;
    end
    if (!keep) begin
      wt(4);
      spi_en <= 1'b0;
      spi_in <= 1'b0;
      wt(4);
    end
  endtask
endmodule // iscp_host

// ===== verification/iscp_top_test.sv
// self-checking bench for the image sensor control port
`timescale 1ns/1ns
`include "iscp_consts.vh"
module iscp_top_test;
  localparam int FOT_CYCLES = 4;
  localparam int READOUT_CYCLES = 8;
  logic clk;
  logic rstn;
  logic system_reset_low;
  logic frame_req;
  logic exposure_pin_one;
  wire spi_clk, spi_en, spi_in, spi_out, integration_phase;
  wire frame_overhead_time, readout_active, data_out, frame_done;
  int failures = 0;
  int compares = 0;
  int seed = 32'h2790a99b;
  int cycles = 0;
  int done_cnt = 0;
  int run_len = 0;
  int first_len = 0;
  int ovl = 0;
  logic [15:0] mem [0:127];
  logic [6:0] adr [0:3];
  logic [15:0] rd;
  logic [15:0] e;
  iscp_top #(.FOT_CYCLES(FOT_CYCLES), .READOUT_CYCLES(READOUT_CYCLES))
    u_dut (.*);
  iscp_host u_host (.*);
  initial begin
    // supplies count as settled before the clock starts
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ----
  // monitors and hang guard
  // ----
  always @(posedge clk) begin
    cycles++;
    if (frame_done === 1'b1) done_cnt++;
    if (integration_phase === 1'b1 && readout_active === 1'b1) ovl++;
    if (integration_phase === 1'b1) run_len++;
    else if (run_len > 0) begin
      if (first_len == 0) first_len = run_len;
      run_len = 0;
    end
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  // ----
  // helpers
  // ----
  function automatic logic [15:0] want(input logic [15:0] fc, int extra);
    return (fc == 16'h0000 ? 16'h0001 : fc) + 16'(extra);
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d, bit k);
    u_host.xfer({1'b1, a, d}, k, rd);
    mem[a] = d;
  endtask
  task automatic rdck(input logic [6:0] a);
    u_host.xfer({1'b0, a, 16'($random(seed))}, 1'b0, rd);
    chk("register", rd, mem[a]);
  endtask
  task automatic defaults;
    for (int i = 0; i < 128; i++) mem[i] = `ISCP_REG_RST;
    mem[`ISCP_ADDR_FRAME_COUNT] = `ISCP_FRAME_COUNT_RST;
  endtask
  task automatic pulse(input bit ext);
    @(posedge clk);
    if (ext) exposure_pin_one <= 1'b1;
    else frame_req <= 1'b1;
    repeat (12) @(posedge clk);
    exposure_pin_one <= 1'b0;
    frame_req <= 1'b0;
  endtask
  task automatic clear;
    @(negedge clk);
    done_cnt = 0;
    first_len = 0;
    ovl = 0;
  endtask
  task automatic frames(input logic [15:0] n);
    for (int k = 0; k < 3000 && done_cnt < n; k++) @(negedge clk);
    repeat (60) @(negedge clk);
    chk("frames", 16'(done_cnt), n);
  endtask
  task automatic complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    rstn = 1'b0;
    system_reset_low = 1'b0;
    frame_req = 1'b0;
    exposure_pin_one = 1'b0;
    defaults();
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    system_reset_low <= 1'b1;
    repeat (24) @(posedge clk);
    rdck(`ISCP_ADDR_FRAME_COUNT);
    rdck(`ISCP_ADDR_EXPOSURE_SELECT);
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      adr[i] = 7'($random(seed));
      wr(adr[i], 16'($random(seed)), i < 3);
    end
    for (int i = 0; i < 4; i++) rdck(adr[i]);
    chk("spi_out", {15'h0000, spi_out}, 16'h0000);
    $display("test serial done");
    system_reset_low <= 1'b0;
    repeat (6) @(posedge clk);
    system_reset_low <= 1'b1;
    repeat (24) @(posedge clk);
    defaults();
    rdck(adr[0]);
    rdck(`ISCP_ADDR_FRAME_COUNT);
    $display("test reset pin done");
    // short exposure so the second frame waits on the readout
    e = 16'h0003 + 16'($random(seed) & 3);
    wr(`ISCP_ADDR_PIXEL_RESOLUTION, 16'h000c, 1'b0);
    wr(`ISCP_ADDR_EXPOSURE_TIME_LO, e, 1'b1);
    wr(`ISCP_ADDR_EXPOSURE_TIME_HI, 16'h0000, 1'b1);
    wr(`ISCP_ADDR_FRAME_COUNT, 16'h0002, 1'b0);
    clear();
    pulse(1'b0);
    frames(want(16'h0002, 0));
    chk("exposure", 16'(first_len), e);
    chk("overlap", {15'h0000, ovl > 0}, 16'h0001);
    $display("test internal done");
    wr(`ISCP_ADDR_EXPOSURE_TIME_LO, 16'h0050, 1'b1);
    wr(`ISCP_ADDR_FRAME_COUNT, 16'h0001, 1'b0);
    clear();
    pulse(1'b0);
    repeat (3) begin
      repeat (4) @(posedge clk);
      pulse(1'b0);
    end
    frames(want(16'h0001, 2));
    $display("test early requests done");
    wr(`ISCP_ADDR_EXPOSURE_TIME_LO, 16'h0003, 1'b0);
    clear();
    @(posedge clk);
    frame_req <= 1'b1;
    repeat (100) @(posedge clk);
    frame_req <= 1'b0;
    repeat (60) @(negedge clk);
    chk("continuous", {15'h0000, done_cnt > 3}, 16'h0001);
    $display("test continuous done");
    wr(`ISCP_ADDR_EXPOSURE_SELECT, 16'h0001, 1'b0);
    clear();
    pulse(1'b1);
    repeat (30) @(negedge clk);
    chk("external", {15'h0000, integration_phase}, 16'h0001);
    pulse(1'b0);
    frames(16'h0001);
    $display("test external done");
    complete_run();
  end
endmodule // iscp_top_test
